/* File: include/aslc_pkg.sv */
// package for the converter selection latch and sleep control block
// assumes one cpu clock; converter clock made here by a prescaler
// How it works
// - cpu selection sits in a temporary register, copied to active while idle.
// - active selection frozen during conversion, copying resumes in last eight converter cycles.
// - conversion begins on the second cpu clock edge after the start bit write.
// - amplified conversion end clears the start bit.
// - current source selected disconnects the reference pin from the internal network.
// - noise reduction or idle sleep with conditions met starts a conversion once halted.
// - completion raises the interrupt request, waking the cpu in noise reduction sleep.
// - converter stays enabled in other sleep modes.
// - start bit reads one throughout a conversion, cleared by hardware at completion.
// - normal conversion 15.5 converter cycles, first after enable 25.
// - trigger rising edge resets prescaler and starts conversion; edges while busy ignored.
package aslc_pkg;
   localparam int CHAN_W = 5;
   localparam int REF_W = 2;
   localparam int PRESC_W = 7;
   // half cycles: 15.5 and 25 converter cycles doubled
   localparam logic [5:0] NORMAL_HALF = 6'h1F;
   localparam logic [5:0] FIRST_HALF = 6'h32;
   localparam logic [5:0] UNLOCK_HALF = 6'h10;
   localparam logic [1:0] START_DELAY = 2'h2;
   localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
   localparam logic [REF_W-1:0] REF_RST = 2'h0;
   typedef struct packed {
      logic [REF_W-1:0] ref_sel;
      logic [CHAN_W-1:0] chan;
   } aslc_sel_t;
   typedef enum logic [1:0] {SLP_NONE, SLP_IDLE, SLP_NOISE, SLP_OTHER} aslc_sleep_t;
endpackage

/* File: design/aslc_ctrl.sv */
// selection latch, start timing, conversion timer and sleep start
// assumes cpu write strobes are on core_clk_i; trigger pin is asynchronous
`timescale 1ns/1ps
`default_nettype none
module aslc_ctrl (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic sel_wr_i,
   input wire aslc_pkg::aslc_sel_t sel_wdata_i,
   output aslc_pkg::aslc_sel_t sel_rdata_o,
   output aslc_pkg::aslc_sel_t active_sel_o,
   input wire logic converter_enable_i,
   input wire logic auto_trigger_enable_i,
   input wire logic start_wr_i,
   input wire logic trigger_i,
   input wire logic amplified_i,
   input wire logic [2:0] prescale_i,
   input wire logic current_source_enable_i,
   input wire logic intr_enable_i,
   input wire aslc_pkg::aslc_sleep_t sleep_mode_i,
   input wire logic cpu_halted_i,
   output logic start_conversion_bit_o,
   output logic busy_o,
   output logic conv_clk_o,
   output logic done_pulse_o,
   output logic irq_req_o,
   output logic ref_pin_connect_o,
   output logic converter_power_o
);
   import aslc_pkg::*;
   logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
   aslc_sel_t tmp_reg, tmp_next, act_reg, act_next;
   logic start_reg, start_next, busy_reg, busy_next, first_reg, first_next;
   logic [1:0] dly_reg, dly_next;
   logic [5:0] half_reg, half_next;
   logic [PRESC_W-1:0] pre_reg, pre_next;
   logic done_reg, done_next, irq_reg, irq_next, slp_reg, slp_next;
   logic trig_rise, tick, sleep_go, kick;
   function automatic logic [PRESC_W-1:0] presc_div(input logic [2:0] code);
      presc_div = (code == 3'h0) ? 7'h01 : 7'((8'h01 << code) - 8'h01);
   endfunction
   // trigger pin passes two flops before edge detect
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         trig_s1_reg <= 1'b0;
         trig_s2_reg <= 1'b0;
         trig_s3_reg <= 1'b0;
      end else begin
         trig_s1_reg <= trigger_i;
         trig_s2_reg <= trig_s1_reg;
         trig_s3_reg <= trig_s2_reg;
      end
   end
   assign trig_rise = trig_s2_reg & ~trig_s3_reg;
   // compare with >= so a smaller prescale setting never lets the count run on to wrap
   assign tick = (pre_reg >= presc_div(prescale_i));
   assign sleep_go = (sleep_mode_i == SLP_IDLE || sleep_mode_i == SLP_NOISE) && cpu_halted_i &&
                     !auto_trigger_enable_i && converter_enable_i && intr_enable_i && !busy_reg &&
                     !start_reg && !slp_reg;
   assign kick = start_wr_i | sleep_go;
   always_comb begin
      tmp_next = tmp_reg;
      act_next = act_reg;
      start_next = start_reg;
      busy_next = busy_reg;
      first_next = first_reg;
      dly_next = dly_reg;
      half_next = half_reg;
      pre_next = tick ? '0 : PRESC_W'(pre_reg + 1'b1);
      done_next = 1'b0;
      irq_next = 1'b0;
      slp_next = slp_reg & (sleep_mode_i != SLP_NONE);
      if (sel_wr_i) begin
         tmp_next = sel_wdata_i;
      end
      // copy while idle or in last eight cycles
      if (!busy_reg || (dly_reg == 2'h0 && half_reg <= UNLOCK_HALF)) begin
         act_next = tmp_reg;
      end
      // enable low clears the prescaler to zero and makes the next conversion a long first one
      if (!converter_enable_i) begin
         start_next = 1'b0;
         busy_next = 1'b0;
         first_next = 1'b1;
         dly_next = 2'h0;
         pre_next = '0;
      end else if (!busy_reg) begin
         // trigger edge resets prescaler and starts
         if (auto_trigger_enable_i && trig_rise) begin
            busy_next = 1'b1;
            pre_next = '0;
            half_next = first_reg ? FIRST_HALF : NORMAL_HALF;
            start_next = 1'b1;
         end else if (kick) begin
            start_next = 1'b1;
            busy_next = 1'b1;
            dly_next = START_DELAY;
            slp_next = slp_reg | sleep_go;
            half_next = first_reg ? FIRST_HALF : NORMAL_HALF;
         end
      end else if (dly_reg != 2'h0) begin
         dly_next = 2'(dly_reg - 2'h1);
      end else if (tick) begin
         // count half cycles down to completion
         // 31 half cycles end on the 16th tick, so 15.5 rounds up
         if (half_reg <= 6'h2) begin
            busy_next = 1'b0;
            first_next = 1'b0;
            done_next = 1'b1;
            irq_next = intr_enable_i;
            start_next = 1'b0;
         end else begin
            half_next = 6'(half_reg - 6'h2);
         end
      end
      // a write on the completion edge must not leave the bit up with nothing running
      if (converter_enable_i && start_wr_i && busy_reg && busy_next && !amplified_i) begin
         start_next = 1'b1;
      end
   end
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tmp_reg <= '{ref_sel: REF_RST, chan: CHAN_RST};
         act_reg <= '{ref_sel: REF_RST, chan: CHAN_RST};
         start_reg <= 1'b0;
         busy_reg <= 1'b0;
         first_reg <= 1'b1;
         dly_reg <= 2'h0;
         half_reg <= 6'h00;
         pre_reg <= '0;
         done_reg <= 1'b0;
         irq_reg <= 1'b0;
         slp_reg <= 1'b0;
      end else begin
         tmp_reg <= tmp_next;
         act_reg <= act_next;
         start_reg <= start_next;
         busy_reg <= busy_next;
         first_reg <= first_next;
         dly_reg <= dly_next;
         half_reg <= half_next;
         pre_reg <= pre_next;
         done_reg <= done_next;
         irq_reg <= irq_next;
         slp_reg <= slp_next;
      end
   end
   assign sel_rdata_o = tmp_reg;
   assign active_sel_o = act_reg;
   assign start_conversion_bit_o = start_reg;
   assign busy_o = busy_reg;
   assign conv_clk_o = tick;
   assign done_pulse_o = done_reg;
   // completion request even if woken early
   assign irq_req_o = irq_reg;
   assign ref_pin_connect_o = !current_source_enable_i;
   // power follows enable only, any sleep mode
   assign converter_power_o = converter_enable_i;

   // checks sit beside the logic they guard
   AST_START_DELAY: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (converter_enable_i && !busy_reg && start_wr_i && !(auto_trigger_enable_i && trig_rise))
      |=> busy_reg && start_reg && dly_reg == START_DELAY) else $error("start delay wrong");
   AST_LOCK: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (busy_reg && half_reg > UNLOCK_HALF && converter_enable_i && $past(busy_reg))
      |-> $stable(act_reg)) else $error("selection changed while locked");
   AST_UNLOCK_COPY: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (busy_reg && dly_reg == 2'h0 && half_reg <= UNLOCK_HALF)
      |=> act_reg == $past(tmp_reg)) else $error("copy not resumed near the end");
   AST_IDLE_COPY: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !busy_reg
      |=> act_reg == $past(tmp_reg)) else $error("idle copy missing");
   AST_READBACK: assert property (@(posedge core_clk_i) disable iff (rst_i)
      sel_wr_i
      |=> sel_rdata_o == $past(sel_wdata_i)) else $error("readback wrong");
   AST_DONE_CLEAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
      done_reg
      |-> !start_reg) else $error("start bit not cleared");
   AST_BUSY_START: assert property (@(posedge core_clk_i) disable iff (rst_i)
      start_reg == busy_reg)
      else $error("start bit differs from busy");
   AST_DONE_IDLE: assert property (@(posedge core_clk_i) disable iff (rst_i)
      done_reg
      |-> !busy_reg) else $error("busy after completion");
   AST_TRIG: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (converter_enable_i && auto_trigger_enable_i && trig_rise && !busy_reg)
      |=> busy_reg && pre_reg == '0) else $error("trigger not taken");
   AST_EDGE_IGNORED: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (converter_enable_i && busy_reg && trig_rise && half_reg > 6'h2)
      |=> busy_reg && half_reg <= $past(half_reg)) else $error("trigger edge restarted a conversion");
   AST_DISABLE_CLEAR: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !converter_enable_i
      |=> !busy_reg && !start_reg && first_reg) else $error("disable did not clear the conversion");
   AST_REFPIN: assert property (@(posedge core_clk_i) disable iff (rst_i)
      current_source_enable_i
      |-> !ref_pin_connect_o) else $error("reference pin connected");
   AST_SLEEP: assert property (@(posedge core_clk_i) disable iff (rst_i)
      sleep_go
      |=> busy_reg) else $error("sleep conversion not started");
   AST_IRQ: assert property (@(posedge core_clk_i) disable iff (rst_i)
      (done_reg && $past(intr_enable_i))
      |-> irq_req_o) else $error("irq missing");
   AST_IRQ_GATED: assert property (@(posedge core_clk_i) disable iff (rst_i)
      irq_req_o
      |-> done_reg) else $error("irq without completion");
   // covers for the main scenarios
   COV_SINGLE: cover property (@(posedge core_clk_i) disable iff (rst_i)
      start_wr_i ##[1:1000] done_reg);
   COV_TRIG: cover property (@(posedge core_clk_i) disable iff (rst_i)
      trig_rise && auto_trigger_enable_i);
   COV_SLEEP: cover property (@(posedge core_clk_i) disable iff (rst_i)
      sleep_go ##[1:1000] irq_req_o);
   COV_AMP_DONE: cover property (@(posedge core_clk_i) disable iff (rst_i)
      done_reg && amplified_i);
   COV_TRIG_IGNORED: cover property (@(posedge core_clk_i) disable iff (rst_i)
      busy_reg && trig_rise && auto_trigger_enable_i);
endmodule
`default_nettype wire

/* File: verification/aslc_core_model.sv */
// analog converter core stand-in: samples the active selection
// assumes busy and converter tick come from the control block
`timescale 1ns/1ps
`default_nettype none
module aslc_core_model
   import aslc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic busy_i,
   input wire logic conv_clk_i,
   input wire aslc_pkg::aslc_sel_t sel_i,
   output aslc_pkg::aslc_sel_t held_sel_o
);
   logic [5:0] tick_reg;
   // sample and hold early in the conversion, on the fourth converter tick while busy, so a locked selection matters
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tick_reg <= 6'h00;
         held_sel_o <= '0;
      end else if (!busy_i) begin
         tick_reg <= 6'h00;
      end else if (conv_clk_i) begin
         tick_reg <= tick_reg + 6'h01;
         if (tick_reg == 6'h03) begin
            held_sel_o <= sel_i;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/adc_select_latch_sleep_ctrl_tb_top.sv */
// testbench of the selection latch and sleep start control
// assumes a 40 MHz cpu clock and the core model beside the block
`timescale 1ns/1ps
`default_nettype none
module adc_select_latch_sleep_ctrl_tb_top;
   import aslc_pkg::*;
   logic core_clk_i = 0, rst_i = 1, sel_wr_i = 0, converter_enable_i = 0, auto_trigger_enable_i = 0;
   logic start_wr_i = 0, trigger_i = 0, amplified_i = 0, current_source_enable_i = 0, intr_enable_i = 0;
   logic cpu_halted_i = 0, start_conversion_bit_o, busy_o, conv_clk_o, done_pulse_o, irq_req_o;
   logic ref_pin_connect_o, converter_power_o;
   logic [2:0] prescale_i = 3'h0;
   aslc_sel_t sel_wdata_i = '0, sel_rdata_o, active_sel_o, held_sel;
   aslc_sleep_t sleep_mode_i = SLP_NONE;
   int mismatches = 0, n_compared = 0, n;
   // no port pin shared with the converter is driven by this bench
   aslc_ctrl dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .sel_wr_i(sel_wr_i), .sel_wdata_i(sel_wdata_i),
      .sel_rdata_o(sel_rdata_o), .active_sel_o(active_sel_o), .converter_enable_i(converter_enable_i),
      .auto_trigger_enable_i(auto_trigger_enable_i), .start_wr_i(start_wr_i), .trigger_i(trigger_i),
      .amplified_i(amplified_i), .prescale_i(prescale_i), .current_source_enable_i(current_source_enable_i),
      .intr_enable_i(intr_enable_i), .sleep_mode_i(sleep_mode_i), .cpu_halted_i(cpu_halted_i),
      .start_conversion_bit_o(start_conversion_bit_o), .busy_o(busy_o), .conv_clk_o(conv_clk_o),
      .done_pulse_o(done_pulse_o), .irq_req_o(irq_req_o), .ref_pin_connect_o(ref_pin_connect_o),
      .converter_power_o(converter_power_o));
   aslc_core_model core_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .busy_i(busy_o), .conv_clk_i(conv_clk_o),
      .sel_i(active_sel_o), .held_sel_o(held_sel));
   initial begin
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input logic [6:0] got, input logic [6:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) begin
         @(posedge core_clk_i);
         #2;
      end
   endtask
   // bounded wait; done stands one cycle, so it is seen here
   task automatic wait_done();
      n = 0;
      while (done_pulse_o !== 1'b1 && n < 200) begin
         cyc(1);
         n++;
      end
      chk(n < 200, 1);
   endtask
   task automatic pulse_start();
      start_wr_i = 1;
      cyc(1);
      start_wr_i = 0;
   endtask
   task automatic write_sel(input logic [6:0] v);
      sel_wdata_i = v;
      sel_wr_i = 1;
      cyc(1);
      sel_wr_i = 0;
      cyc(1);
   endtask
   task automatic end_sim();
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      mismatches++;
      end_sim();
   end
   initial begin
      cyc(16);
      rst_i = 0;
      chk({start_conversion_bit_o, busy_o}, 0);
      chk(active_sel_o, 0);
      current_source_enable_i = 1;
      cyc(1);
      chk(ref_pin_connect_o, 0); // pin cut off
      current_source_enable_i = 0;
      cyc(1);
      chk(ref_pin_connect_o, 1); // pin back
      converter_enable_i = 1;
      // channel chosen before the first start
      write_sel(7'h45);
      chk(active_sel_o, 7'h45); // idle copy
      prescale_i = 3'h2;
      n = 0;
      repeat (8) begin
         cyc(1);
         n += int'(conv_clk_o);
      end
      chk(7'(n), 7'h02); // converter tick every fourth cycle
      prescale_i = 3'h0;
      cyc(1);
      pulse_start();
      chk(start_conversion_bit_o, 1); // start taken
      // new selection only after two converter cycles
      cyc(4);
      // reference switched here; no result is judged, so none is kept
      write_sel(7'h2A);
      chk(sel_rdata_o, 7'h2A); // temp readback
      chk(active_sel_o, 7'h45); // locked
      chk(start_conversion_bit_o, 1); // high while busy
      wait_done();
      chk(n > 35, 1); // first is long
      chk(held_sel, 7'h45); // old one sampled
      cyc(1);
      chk(start_conversion_bit_o, 0); // cleared at end
      chk(active_sel_o, 7'h2A); // copy resumed
      amplified_i = 1;
      pulse_start();
      cyc(6);
      pulse_start();
      wait_done();
      chk(n < 40, 1); // normal is short
      cyc(2);
      chk(start_conversion_bit_o, 0); // amplified clears
      amplified_i = 0;
      intr_enable_i = 1;
      sleep_mode_i = SLP_OTHER;
      cpu_halted_i = 1;
      cyc(10);
      chk({busy_o, converter_power_o}, 1); // stays powered
      converter_enable_i = 0;
      cyc(1);
      converter_enable_i = 1;
      sleep_mode_i = SLP_NOISE;
      wait_done(); // sleep start
      chk(n > 35, 1); // first after re-enable is long
      chk(irq_req_o, 1); // wake request
      cpu_halted_i = 0;
      sleep_mode_i = SLP_NONE;
      cyc(4);
      // selection left alone while auto trigger runs
      auto_trigger_enable_i = 1;
      trigger_i = 1;
      cyc(6);
      chk(busy_o, 1); // edge starts
      trigger_i = 0;
      cyc(3);
      trigger_i = 1;
      wait_done();
      cyc(8);
      chk(busy_o, 0); // busy edge ignored
      end_sim();
   end
endmodule
`default_nettype wire
